// File: design/crc_pkg.sv
/*
 * Shared constants, types and register map of the card reader channel
 * command and status block.
 * Assumes one system clock; used by every design file of the block.
 */
package crc_pkg;

   // register map, byte offsets
   localparam int REG_AW = 8;
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_TEST_INIT = 8'h08;
   localparam logic [7:0] OFS_TEST_ERR = 8'h0C;
   localparam logic [7:0] OFS_INTCTL = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_ADDR = 8'h18;
   localparam logic [7:0] OFS_COUNT = 8'h1C;

   // command function codes
   localparam logic [15:0] FC_TERM = 16'h1000;
   localparam logic [15:0] FC_OFFSET = 16'h2000;
   localparam logic [15:0] FC_READ_XLT = 16'h9000;
   localparam logic [15:0] FC_READ_AUTO = 16'h9400;
   localparam logic [15:0] FC_READ_BIN = 16'h9800;
   localparam logic [15:0] FC_RST = 16'h0000;

   // interrupt control word bits
   localparam int INT_REQ_BIT = 0;
   localparam int INT_EN_BIT = 1;
   localparam int INT_DIS_BIT = 2;
   localparam int INT_ACT_BIT = 3;
   localparam int INT_DEACT_BIT = 4;

   // condition bit positions in a test answer
   localparam int CC1_BIT = 3;
   localparam int CC2_BIT = 2;
   localparam int CC3_BIT = 1;
   localparam int CC4_BIT = 0;

   // card column: bit 11 row 12 ... bit 0 row 9
   localparam int COL_W = 12;
   localparam logic [11:0] COL_BIN_MARK = 12'h005;
   localparam int MEM_AW = 24;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_FETCH0 = 5'h02,
      ST_FETCH1 = 5'h04,
      ST_WAIT_COL = 5'h08,
      ST_WRITE = 5'h10
   } crc_phase_t;

   typedef enum logic [1:0] {
      MODE_XLT = 2'h0,
      MODE_AUTO = 2'h1,
      MODE_BIN = 2'h2
   } crc_mode_t;

   typedef struct packed {
      logic req;
      logic wr;
      logic [23:0] addr;
      logic [31:0] wdata;
   } crc_mem_req_t;

   typedef struct packed {
      logic ack;
      logic inv;
      logic perr;
      logic [31:0] rdata;
   } crc_mem_rsp_t;

   typedef struct packed {
      logic inv;
      logic perr;
      logic pv;
      logic under;
   } crc_err_t;

endpackage : crc_pkg

// File: design/crc_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs arrive asynchronously to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
module crc_sync
   import crc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   logic [WIDTH-1:0] ff1_r;
   logic [WIDTH-1:0] ff2_r;
   logic [WIDTH-1:0] ff3_r;
   logic [WIDTH-1:0] q_r;

   // a bit changes only once stages two and three agree
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ff1_r <= '0;
         ff2_r <= '0;
         ff3_r <= '0;
         q_r <= '0;
      end else begin
         ff1_r <= d_in;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         q_r <= (ff2_r & ff3_r) | (q_r & (ff2_r | ff3_r));
      end
   end

   assign q_out = q_r;

endmodule : crc_sync
`default_nettype wire

// File: design/crc_channel.sv
/*
 * Card reader channel: command decode, two-level status test,
 * descriptor fetch, autonomous column transfer and service interrupt.
 * Assumes a memory controller on the same clock answering MEM_REQ_OUT
 * with a one-cycle ack, and card reader pins asynchronous to the clock.
 */
// Local design decisions: the plain strobed port and the placing of the registers.
// How it works
// - five function codes accepted, two control, three start card reads.
// - special control code pulses the stacker offset output.
// - code 1000 terminates the transfer and stops further reading.
// - code 9000 starts reading in translate mode.
// - code 9400 starts reading in automatic mode.
// - code 9800 starts reading binary, column data untranslated.
// - two test levels, each answering four condition bits.
// - level 8000 returns initial status bits for the host status word.
// - initial level first bit always reads zero.
// - initial level second bit set while transferring.
// - initial level third bit set when a channel error is latched while idle.
// - initial level fourth bit set when the reader is inoperable while idle and no error is latched.
// - initial bits mutually exclusive; all ones means no channel.
// - error level first bit: invalid memory access.
// - error level second bit: parity error fetching descriptor.
// - unperformable command sets third error bit; refused start while idle interrupts at once, bad code while idle does not.
// - error level fourth bit: column lost before reaching memory.
// - transfer runs without host help once started.
// - completion raises the service interrupt.
// - status assembled from channel and reader, returned on request.
// - interrupt request, enable, disable, activate, deactivate commands.
// - address increments and count decrements per write; zero ends.
// - start fetches two descriptor words with two memory reads.
`timescale 1ns/100ps
`default_nettype none
module crc_channel
   import crc_pkg::*;
(
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [31:0] REG_RDATA_OUT,
   output var crc_mem_req_t MEM_REQ_OUT,
   input wire crc_mem_rsp_t MEM_RSP_IN,
   input wire logic [11:0] CR_COL_IN,
   input wire logic CR_COL_VALID_IN,
   input wire logic CR_INOP_IN,
   output logic CR_FEED_OUT,
   output logic CR_OFFSET_OUT,
   output logic SI_OUT
);

   typedef struct packed {
      crc_phase_t phase;
      crc_mode_t mode;
      logic bin_now;
      logic first_col;
      logic [15:0] func;
      logic func_ok;
      logic [23:0] io_command_descriptor_addr;
      logic [23:0] mem_addr;
      logic [15:0] count;
      logic [11:0] col_buf;
      logic col_full;
      logic valid_d;
      crc_err_t err;
      logic int_req;
      logic int_en;
      logic int_act;
      logic si;
      crc_mem_req_t mem;
      logic offset;
      logic feed;
      logic [31:0] rd_data;
   } crc_regs_t;

   crc_regs_t s_r;
   crc_regs_t s_nxt;
   logic [13:0] pin_sync;
   logic col_valid;
   logic inop;
   logic [11:0] col_data;

   crc_sync #(.WIDTH(14)) u_sync (
      .clk_in(CLOCK_IN),
      .rst_b_in(RST_B_IN),
      .d_in({CR_INOP_IN, CR_COL_VALID_IN, CR_COL_IN}),
      .q_out(pin_sync)
   );

   assign inop = pin_sync[13];
   assign col_valid = pin_sync[12];
   assign col_data = pin_sync[11:0];

   // hollerith zone plus lowest-numbered digit row to an 8-bit code
   function automatic logic [7:0] crc_xlat(input logic [11:0] col);
      logic [3:0] digit;
      digit = 4'h0;
      for (int i = 0; i < 9; i++) begin
         if (col[i]) begin
            digit = 4'(9 - i);
         end
      end
      return {1'b0, col[11:9], digit};
   endfunction : crc_xlat

   function automatic logic [31:0] crc_fmt(input logic bin,
                                           input logic [11:0] col);
      if (bin) begin
         return {20'h00000, col};
      end
      return {24'h000000, crc_xlat(col)};
   endfunction : crc_fmt

   function automatic logic crc_is_read(input logic [15:0] fc);
      return (fc == FC_READ_XLT) || (fc == FC_READ_AUTO) ||
         (fc == FC_READ_BIN);
   endfunction : crc_is_read

   // current operation ends: reader stopped, completion interrupt
   function automatic crc_regs_t crc_finish(input crc_regs_t s);
      crc_regs_t t;
      t = s;
      t.phase = ST_IDLE;
      t.feed = 1'b0;
      t.col_full = 1'b0;
      t.mem.req = 1'b0;
      t.mem.wr = 1'b0;
      t.int_req = 1'b1;
      return t;
   endfunction : crc_finish

   always_comb begin
      logic active;
      logic [3:0] cc_init;
      logic [3:0] cc_err;
      logic [15:0] wfc;
      s_nxt = s_r;
      active = (s_r.phase != ST_IDLE);
      wfc = REG_WDATA_IN[15:0];
      s_nxt.offset = 1'b0;
      s_nxt.valid_d = col_valid;
      s_nxt.rd_data = 32'h00000000;

      // status assembly: priority makes the bits mutually exclusive
      cc_init = 4'h0;
      cc_init[CC1_BIT] = 1'b0;
      cc_init[CC2_BIT] = active;
      cc_init[CC3_BIT] = !active && (s_r.err != '0);
      cc_init[CC4_BIT] = !active && (s_r.err == '0) && inop;
      cc_err = 4'h0;
      cc_err[CC1_BIT] = s_r.err.inv;
      cc_err[CC2_BIT] = s_r.err.perr;
      cc_err[CC3_BIT] = s_r.err.pv;
      cc_err[CC4_BIT] = s_r.err.under;

      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            OFS_CMD: s_nxt.rd_data = {16'h0000, s_r.func};
            OFS_TEST_INIT: s_nxt.rd_data = {28'h0000000, cc_init};
            OFS_TEST_ERR: s_nxt.rd_data = {28'h0000000, cc_err};
            OFS_INTCTL: s_nxt.rd_data = {29'h00000000, s_r.int_act,
               s_r.int_en, s_r.int_req};
            OFS_STATUS: s_nxt.rd_data = {8'h00, 3'h0, s_r.phase,
               2'h0, s_r.mode, 1'b0, s_r.bin_now, s_r.feed, inop,
               4'h0, s_r.err};
            OFS_ADDR: s_nxt.rd_data = {8'h00, s_r.mem_addr};
            OFS_COUNT: s_nxt.rd_data = {16'h0000, s_r.count};
            default: s_nxt.rd_data = 32'h00000000;
         endcase
      end

      // column arrival from the reader
      if (col_valid && !s_r.valid_d && s_r.feed) begin
         // in ST_WAIT_COL the buffer drains this cycle, so no loss
         if (s_r.col_full && s_r.phase != ST_WAIT_COL) begin
            s_nxt.err.under = 1'b1;
         end else begin
            s_nxt.col_buf = col_data;
            s_nxt.col_full = 1'b1;
         end
      end

      // autonomous transfer sequence
      unique case (s_r.phase)
         ST_IDLE: begin
         end
         ST_FETCH0: begin
            if (MEM_RSP_IN.ack) begin
               if (MEM_RSP_IN.inv || MEM_RSP_IN.perr) begin
                  s_nxt = crc_finish(s_nxt);
                  s_nxt.err.inv = s_r.err.inv | MEM_RSP_IN.inv;
                  s_nxt.err.perr = s_r.err.perr | MEM_RSP_IN.perr;
               end else begin
                  s_nxt.mem_addr = MEM_RSP_IN.rdata[23:0];
                  s_nxt.mem.addr = s_r.io_command_descriptor_addr + 24'h000001;
                  s_nxt.phase = ST_FETCH1;
               end
            end
         end
         ST_FETCH1: begin
            if (MEM_RSP_IN.ack) begin
               if (MEM_RSP_IN.inv || MEM_RSP_IN.perr) begin
                  s_nxt = crc_finish(s_nxt);
                  s_nxt.err.inv = s_r.err.inv | MEM_RSP_IN.inv;
                  s_nxt.err.perr = s_r.err.perr | MEM_RSP_IN.perr;
               end else if (MEM_RSP_IN.rdata[15:0] == 16'h0000) begin
                  s_nxt = crc_finish(s_nxt);
               end else begin
                  s_nxt.count = MEM_RSP_IN.rdata[15:0];
                  s_nxt.mem.req = 1'b0;
                  s_nxt.feed = 1'b1;
                  s_nxt.phase = ST_WAIT_COL;
               end
            end
         end
         ST_WAIT_COL: begin
            if (s_r.col_full) begin
               logic bin;
               bin = (s_r.mode == MODE_BIN) || s_r.bin_now;
               if (s_r.first_col && s_r.mode == MODE_AUTO &&
                   (s_r.col_buf & COL_BIN_MARK) == COL_BIN_MARK) begin
                  bin = 1'b1;
               end
               s_nxt.bin_now = bin;
               s_nxt.first_col = 1'b0;
               s_nxt.col_full = 1'b0;
               s_nxt.mem.req = 1'b1;
               s_nxt.mem.wr = 1'b1;
               s_nxt.mem.addr = s_r.mem_addr;
               s_nxt.mem.wdata = crc_fmt(bin, s_r.col_buf);
               s_nxt.phase = ST_WRITE;
               if (col_valid && !s_r.valid_d && s_r.feed) begin
                  s_nxt.col_buf = col_data;
                  s_nxt.col_full = 1'b1;
               end
            end
         end
         ST_WRITE: begin
            if (MEM_RSP_IN.ack) begin
               s_nxt.mem.req = 1'b0;
               s_nxt.mem.wr = 1'b0;
               if (MEM_RSP_IN.inv) begin
                  s_nxt = crc_finish(s_nxt);
                  s_nxt.err.inv = 1'b1;
               end else begin
                  s_nxt.mem_addr = s_r.mem_addr + 24'h000001;
                  s_nxt.count = s_r.count - 16'h0001;
                  if (s_r.count == 16'h0001) begin
                     s_nxt = crc_finish(s_nxt);
                  end else begin
                     s_nxt.phase = ST_WAIT_COL;
                  end
               end
            end
         end
      endcase

      // command function code
      if (REG_WR_IN && REG_ADDR_IN == OFS_CMD) begin
         if (wfc == FC_TERM) begin
            if (active) begin
               s_nxt = crc_finish(s_nxt);
            end
            s_nxt.feed = 1'b0;
            s_nxt.col_full = 1'b0;
            s_nxt.func_ok = 1'b0;
         end else if (wfc == FC_OFFSET) begin
            s_nxt.offset = 1'b1;
         end else if (crc_is_read(wfc) && !active) begin
            s_nxt.func = wfc;
            s_nxt.func_ok = 1'b1;
         end else begin
            s_nxt.err.pv = 1'b1;
         end
      end

      // start: fetch descriptor for the latched read command
      if (REG_WR_IN && REG_ADDR_IN == OFS_START) begin
         if (active || !s_r.func_ok) begin
            s_nxt.err.pv = 1'b1;
            if (!active) begin
               s_nxt.int_req = 1'b1;
            end
         end else begin
            s_nxt.err = '0;
            s_nxt.io_command_descriptor_addr = REG_WDATA_IN[23:0];
            s_nxt.mem.req = 1'b1;
            s_nxt.mem.wr = 1'b0;
            s_nxt.mem.addr = REG_WDATA_IN[23:0];
            s_nxt.first_col = 1'b1;
            s_nxt.bin_now = 1'b0;
            s_nxt.col_full = 1'b0;
            s_nxt.func_ok = 1'b0;
            s_nxt.phase = ST_FETCH0;
            if (s_r.func == FC_READ_BIN) begin
               s_nxt.mode = MODE_BIN;
            end else if (s_r.func == FC_READ_AUTO) begin
               s_nxt.mode = MODE_AUTO;
            end else begin
               s_nxt.mode = MODE_XLT;
            end
         end
      end

      // interrupt control; hardware requests win over clears
      if (REG_WR_IN && REG_ADDR_IN == OFS_INTCTL) begin
         if (REG_WDATA_IN[INT_DIS_BIT]) begin
            s_nxt.int_en = 1'b0;
         end
         if (REG_WDATA_IN[INT_EN_BIT]) begin
            s_nxt.int_en = 1'b1;
         end
         if (REG_WDATA_IN[INT_DEACT_BIT]) begin
            s_nxt.int_act = 1'b0;
         end
         if (REG_WDATA_IN[INT_ACT_BIT]) begin
            s_nxt.int_act = 1'b1;
            s_nxt.int_req = s_nxt.int_req && (!s_r.int_req ||
               (active && s_nxt.phase == ST_IDLE));
         end
         if (REG_WDATA_IN[INT_REQ_BIT]) begin
            s_nxt.int_req = 1'b1;
         end
      end
      s_nxt.si = s_nxt.int_req && s_nxt.int_en && !s_nxt.int_act;
   end

   always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         s_r <= '0;
         s_r.phase <= ST_IDLE;
         s_r.mode <= MODE_XLT;
         s_r.func <= FC_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign REG_RDATA_OUT = s_r.rd_data;
   assign MEM_REQ_OUT = s_r.mem;
   assign CR_FEED_OUT = s_r.feed;
   assign CR_OFFSET_OUT = s_r.offset;
   assign SI_OUT = s_r.si;

endmodule : crc_channel
`default_nettype wire

// File: bench/crc_channel_properties.sv
/* Port assertions of the card reader channel.
   Bound to crc_channel; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module crc_channel_chk
   import crc_pkg::*;
(
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [31:0] REG_RDATA_OUT,
   input wire crc_mem_req_t MEM_REQ_OUT,
   input wire crc_mem_rsp_t MEM_RSP_IN,
   input wire logic CR_FEED_OUT,
   input wire logic CR_OFFSET_OUT,
   input wire logic SI_OUT
);
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_B_IN);
   logic wcmd;
   logic rinit;
   assign wcmd = REG_WR_IN && REG_ADDR_IN == OFS_CMD;
   assign rinit = REG_RD_IN && REG_ADDR_IN == OFS_TEST_INIT;
   a_rdata_quiet: assert property (
      !REG_RD_IN |=> REG_RDATA_OUT == 32'h0) else $error("stray read data");
   a_init_exclusive: assert property (
      rinit |=> $onehot0(REG_RDATA_OUT[3:0]) && REG_RDATA_OUT[31:4] == 0)
      else $error("initial bits not exclusive");
   a_init_delay_zero: assert property (
      rinit |=> !REG_RDATA_OUT[CC1_BIT]) else $error("first bit set");
   a_req_stands: assert property (
      MEM_REQ_OUT.req && !MEM_RSP_IN.ack |=> MEM_REQ_OUT.req
      && $stable(MEM_REQ_OUT.addr) && $stable(MEM_REQ_OUT.wr))
      else $error("memory request dropped early");
   a_addr_steps: assert property (
      MEM_REQ_OUT.req && MEM_RSP_IN.ack && !MEM_RSP_IN.inv
      && !MEM_RSP_IN.perr |=> !MEM_REQ_OUT.req
      || MEM_REQ_OUT.addr == $past(MEM_REQ_OUT.addr) + 24'h1)
      else $error("address did not step");
   a_offset_pulse: assert property (
      wcmd && REG_WDATA_IN[15:0] == FC_OFFSET |->
      ##[1:2] (CR_OFFSET_OUT ##1 !CR_OFFSET_OUT))
      else $error("offset pulse missing");
   a_term_stops: assert property (
      wcmd && REG_WDATA_IN[15:0] == FC_TERM |-> ##[1:2] !CR_FEED_OUT)
      else $error("feed kept after terminate");
   a_no_fetch_feed: assert property (
      CR_FEED_OUT |-> !(MEM_REQ_OUT.req && !MEM_REQ_OUT.wr))
      else $error("fetch while feeding");
   a_si_disable: assert property (
      REG_WR_IN && REG_ADDR_IN == OFS_INTCTL && REG_WDATA_IN[INT_DIS_BIT]
      && !REG_WDATA_IN[INT_EN_BIT] |-> ##[1:2] !SI_OUT)
      else $error("interrupt seen while disabled");
endmodule : crc_channel_chk
bind crc_channel crc_channel_chk u_chk (.*);
`default_nettype wire

// File: bench/crc_mem_model.sv
/* Memory controller model for the channel's memory port.
   Same clock; ack after lat_in idle cycles; error flags from bench. */
`timescale 1ns/100ps
`default_nettype none
module crc_mem_model
   import crc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire crc_mem_req_t req_in,
   input wire logic [7:0] lat_in,
   input wire logic inv_in,
   input wire logic perr_in,
   output var crc_mem_rsp_t rsp_out
);
   logic [31:0] mem [0:511];
   logic [7:0] wait_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wait_r <= 8'h00;
         rsp_out <= '0;
      end else begin
         rsp_out.ack <= 1'b0;
         rsp_out.inv <= 1'b0;
         rsp_out.perr <= 1'b0;
         // data is only valid beside ack
         rsp_out.rdata <= ~rsp_out.rdata;
         if (req_in.req && !rsp_out.ack) begin
            if (wait_r < lat_in) begin
               wait_r <= wait_r + 8'h01;
            end else begin
               wait_r <= 8'h00;
               rsp_out.ack <= 1'b1;
               rsp_out.inv <= inv_in;
               rsp_out.perr <= perr_in & ~req_in.wr;
               if (!req_in.wr) begin
                  rsp_out.rdata <= mem[req_in.addr[8:0]];
               end
            end
         end else if (!req_in.req) begin
            wait_r <= 8'h00;
         end
      end
   end
   // plain process: the bench preloads this array directly
   always @(posedge clk_in) begin
      if (rst_b_in && req_in.req && req_in.wr && !rsp_out.ack &&
          wait_r >= lat_in && !inv_in) begin
         mem[req_in.addr[8:0]] <= req_in.wdata;
      end
   end
endmodule : crc_mem_model
`default_nettype wire

// File: bench/tb.sv
/* Self-checking bench of the card reader channel.
   Register port and reader pins driven here; memory is a model. */
`timescale 1ns/100ps
`default_nettype none
module tb
   import crc_pkg::*;
;
   logic clk = 0, rst_b = 0, wr = 0, rd = 0, cval = 0, inop = 0;
   logic minv = 0, mperr = 0, off_seen = 0, feed, offs, si;
   logic [7:0] addr = 0, lat = 8'h02;
   logic [31:0] wdat = 0, rdat;
   logic [11:0] col = 0;
   crc_mem_req_t mreq;
   crc_mem_rsp_t mrsp;
   int err_total = 0, cmp_count = 0, cyc = 0;
   crc_channel uut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdat), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdat), .MEM_REQ_OUT(mreq), .MEM_RSP_IN(mrsp),
      .CR_COL_IN(col), .CR_COL_VALID_IN(cval), .CR_INOP_IN(inop),
      .CR_FEED_OUT(feed), .CR_OFFSET_OUT(offs), .SI_OUT(si));
   crc_mem_model u_mem (.clk_in(clk), .rst_b_in(rst_b), .req_in(mreq),
      .lat_in(lat), .inv_in(minv), .perr_in(mperr), .rsp_out(mrsp));
   initial forever #20 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (offs === 1'b1) off_seen <= 1'b1;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
   task automatic close_out();
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      tick(1);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      tick(1);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      tick(1);
      rd <= 1'b1;
      addr <= a;
      tick(1);
      rd <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), rdat, e);
   endtask : rchk
   task automatic wait_hi(input bit w);
      int n;
      for (n = 0; n < 600 && (w ? feed : si) !== 1'b1; n++) tick(1);
      @(negedge clk);
      chk(w ? "feed" : "si", {31'h0, w ? feed : si}, 32'h1);
   endtask : wait_hi
   task automatic card(input logic [11:0] c);
      tick(1);
      col <= c;
      tick(6);
      cval <= 1'b1;
      tick(8);
      cval <= 1'b0;
      tick(8);
   endtask : card
   task automatic go(input logic [15:0] fc, input logic [31:0] cnt);
      u_mem.mem[9'h040] = 32'h100;
      u_mem.mem[9'h041] = cnt;
      u_mem.mem[9'h100] = 32'hFFFFFFFF;
      wreg(OFS_CMD, {16'h0, fc});
      wreg(OFS_START, 32'h40);
   endtask : go
   task automatic ack_si();
      wreg(OFS_INTCTL, 32'h8);
      wreg(OFS_INTCTL, 32'h10);
   endtask : ack_si
   initial begin
      tick(5);
      rst_b <= 1'b1;
      rchk(OFS_TEST_INIT, 32'h0);
      rchk(8'h3C, 32'h0);
      tick(1);
      inop <= 1'b1;
      tick(8);
      rchk(OFS_TEST_INIT, 32'h1);
      tick(1);
      inop <= 1'b0;
      wreg(OFS_INTCTL, 32'h2);
      wreg(OFS_CMD, {16'h0, FC_OFFSET});
      tick(3);
      chk("offset", {31'h0, off_seen}, 32'h1);
      go(FC_READ_BIN, 32'h2);
      wait_hi(1);
      rchk(OFS_TEST_INIT, 32'h4);
      card(12'hA5C);
      card(12'h3F1);
      wait_hi(0);
      chk("bin0", u_mem.mem[9'h100], 32'hA5C);
      chk("bin1", u_mem.mem[9'h101], 32'h3F1);
      rchk(OFS_INTCTL, 32'h3);
      wreg(OFS_INTCTL, 32'h4);
      tick(2);
      @(negedge clk);
      chk("si off", {31'h0, si}, 32'h0);
      wreg(OFS_INTCTL, 32'h2);
      ack_si();
      rchk(OFS_INTCTL, 32'h2);
      for (int i = 0; i < 2; i++) begin
         go(i ? FC_READ_AUTO : FC_READ_XLT, 32'h1);
         wait_hi(1);
         card(i ? COL_BIN_MARK : 12'h040);
         wait_hi(0);
         chk("mode", u_mem.mem[9'h100], i ? 32'h5 : 32'h3);
         ack_si();
      end
      go(FC_READ_BIN, 32'h2);
      wait_hi(1);
      wreg(OFS_CMD, {16'h0, FC_READ_XLT});
      wreg(OFS_CMD, {16'h0, FC_TERM});
      wait_hi(0);
      chk("feed", {31'h0, feed}, 32'h0);
      rchk(OFS_TEST_ERR, 32'h2);
      rchk(OFS_TEST_INIT, 32'h2);
      ack_si();
      for (int i = 0; i < 2; i++) begin
         tick(1);
         minv <= i[0];
         mperr <= !i[0];
         go(FC_READ_BIN, 32'h1);
         wait_hi(0);
         rchk(OFS_TEST_ERR, i ? 32'h8 : 32'h4);
         ack_si();
      end
      tick(1);
      minv <= 1'b0;
      mperr <= 1'b0;
      lat <= 8'h3C;
      go(FC_READ_BIN, 32'h3);
      wait_hi(1);
      card(12'h001);
      card(12'h002);
      card(12'h004);
      tick(150);
      lat <= 8'h02;
      wreg(OFS_CMD, {16'h0, FC_TERM});
      rchk(OFS_TEST_ERR, 32'h1);
      rchk(OFS_ADDR, 32'h102);
      rchk(OFS_COUNT, 32'h1);
      chk("kept", u_mem.mem[9'h101], 32'h2);
      ack_si();
      go(FC_READ_BIN, 32'h0);
      wait_hi(0);
      rchk(OFS_TEST_ERR, 32'h0);
      close_out();
   end
endmodule : tb
`default_nettype wire
